/* logic/pxm_pkg.sv */
// Package with the register map, field positions, reset values and timing counts
package pxm_pkg;
    // Register addresses (port 6 for the xMII control, port 6 copy of the MAC controls)
    localparam logic [15:0] ADDR_XMII_CTL1 = 16'h6301;
    localparam logic [15:0] ADDR_MAC_CTL0  = 16'h6400;
    localparam logic [15:0] ADDR_MAC_CTL1  = 16'h6401;
    // xMII control one fields
    localparam int XC1_SPEED_LOW = 6;
    localparam int XC1_RX_DLY    = 4;
    localparam int XC1_TX_DLY    = 3;
    localparam int XC1_ROLE      = 2;
    localparam int XC1_TYPE_LO   = 0;
    localparam logic [7:0] XC1_RESET = 8'h08;
    localparam logic [7:0] XC1_WMASK = 8'hff;
    // MAC control zero fields
    localparam int MC0_STORM = 1;
    localparam int MC0_JUMBO = 0;
    localparam logic [7:0] MC0_RESET = 8'h00;
    localparam logic [7:0] MC0_WMASK = 8'h0b;
    // MAC control one fields
    localparam int MC1_BACKP = 3;
    localparam int MC1_PASS  = 0;
    localparam logic [7:0] MC1_RESET = 8'h00;
    localparam logic [7:0] MC1_WMASK = 8'hbf;
    // Interface type codes
    localparam logic [1:0] TYPE_RGMII = 2'h0;
    localparam logic [1:0] TYPE_RMII  = 2'h1;
    localparam logic [1:0] TYPE_GMII  = 2'h2;
    localparam logic [1:0] TYPE_MII   = 2'h3;
    // Payload limits in bytes
    localparam logic [13:0] PAYLOAD_STD   = 14'h05dc;
    localparam logic [13:0] PAYLOAD_JUMBO = 14'h2328;
    localparam logic [13:0] PAYLOAD_MIN   = 14'h002e;
    // Clock delay: least time rounds up to whole cycles
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_DELAY_PS  = 1500;
    localparam int DLY_CYC_RAW   = (CLK_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] DLY_CYC = (DLY_CYC_RAW < 1) ? 4'h1 : 4'(DLY_CYC_RAW);
    // Reference clock divider: 200 MHz down to 50 MHz, half period in cycles less one
    localparam int SYS_MHZ = 200;
    localparam int REF_MHZ = 50;
    localparam logic [1:0] REF_HALF = 2'(SYS_MHZ / REF_MHZ / 2 - 1);
    // Port mode and rate enumerations
    typedef enum logic [1:0] {
        MODE_RGMII = 2'b00,
        MODE_RMII  = 2'b01,
        MODE_GMII  = 2'b10,
        MODE_MII   = 2'b11
    } pxm_mode_t;
    typedef enum logic [1:0] {
        RATE_10   = 2'b00,
        RATE_100  = 2'b01,
        RATE_1000 = 2'b10
    } pxm_rate_t;
endpackage

/* logic/pxm_ctrl.sv */
// xMII port configuration and switch MAC control register bank
// Contract
// [RULE_01] Speed bit 0 gigabit, 1 uses 10/100
// [RULE_02] Ingress delay bit adds rx clock delay
// [RULE_03] Egress delay bit adds tx clock delay
// [RULE_04] MII role: MAC receives, PHY drives clocks
// [RULE_05] RMII role: accept or generate 50 MHz
// [RULE_06] Type field picks RGMII, RMII, GMII, MII
// [RULE_07] Storm protection gates ingress, resets off
// [RULE_08] Jumbo allows 9000 payload, else 1500
// [RULE_09] Back pressure only enabled and half duplex
// [RULE_10] Bad frames dropped; pass-all mirrors them
// [RULE_11] Pass-all never changes flow frame filtering
// [RULE_12] 10/100 bit: 1 is 100, 0 is 10
// [RULE_13] Read-only reserved bits keep their defaults
module pxm_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_full_duplex,
    input  wire logic        i_speed_100,
    input  wire logic        i_frame_end,
    input  wire logic        i_crc_err,
    input  wire logic [13:0] i_payload_len,
    input  wire logic        i_flow_frame,
    input  wire logic        i_flow_filter_en,
    input  wire logic        i_receive_clock_pin,
    output logic      [7:0]  o_rdata,
    output logic      [1:0]  o_mode,
    output logic      [1:0]  o_rate,
    output logic      [3:0]  o_rx_delay_cyc,
    output logic      [3:0]  o_tx_delay_cyc,
    output logic             o_mii_clk_drive,
    output logic             o_receive_clock_pin_o,
    output logic             o_receive_clock_pin_oe,
    output logic             o_ref_clk_level,
    output logic             o_storm_protect,
    output logic      [13:0] o_max_payload,
    output logic             o_backpressure,
    output logic             o_frame_drop,
    output logic             o_frame_mirror_only
);
    // Whole module state
    typedef struct packed {
        logic [7:0]  xc1;
        logic [7:0]  mc0;
        logic [7:0]  mc1;
        logic [7:0]  rdata;
        logic [1:0]  mode;
        logic [1:0]  rate;
        logic [3:0]  rx_dly;
        logic [3:0]  tx_dly;
        logic        mii_drive;
        logic        ref_oe;
        logic        ref_clk;
        logic [1:0]  ref_cnt;
        logic        ref_lvl;
        logic        storm;
        logic [13:0] max_pay;
        logic        backp;
        logic        drop;
        logic        mirror;
    } pxm_state_t;

    pxm_state_t st_r;
    pxm_state_t st_nxt;

    // Next state: register access, decoded configuration, frame verdict
    always_comb begin
        logic       bad;
        logic       gig;
        logic [1:0] typ;
        bad = 1'b0;
        gig = 1'b0;
        typ = 2'h0;
        st_nxt = st_r;
        // Writes honour the masks so read-only reserved bits stay at default
        if (i_wr) begin
            case (i_addr)
                pxm_pkg::ADDR_XMII_CTL1: st_nxt.xc1 = i_wdata & pxm_pkg::XC1_WMASK;
                pxm_pkg::ADDR_MAC_CTL0:  st_nxt.mc0 = (i_wdata & pxm_pkg::MC0_WMASK) // RULE_13
                                                     | (pxm_pkg::MC0_RESET & ~pxm_pkg::MC0_WMASK);
                pxm_pkg::ADDR_MAC_CTL1:  st_nxt.mc1 = (i_wdata & pxm_pkg::MC1_WMASK) // RULE_13
                                                     | (pxm_pkg::MC1_RESET & ~pxm_pkg::MC1_WMASK);
                default: ;
            endcase
        end
        // Read data is latched one cycle after the strobe; unmapped reads zero
        if (i_rd) begin
            case (i_addr)
                pxm_pkg::ADDR_XMII_CTL1: st_nxt.rdata = st_r.xc1;
                pxm_pkg::ADDR_MAC_CTL0:  st_nxt.rdata = st_r.mc0;
                pxm_pkg::ADDR_MAC_CTL1:  st_nxt.rdata = st_r.mc1;
                default:                 st_nxt.rdata = 8'h00;
            endcase
        end
        // Port mode and rate decode from the stored control
        gig = ~st_r.xc1[pxm_pkg::XC1_SPEED_LOW]; // RULE_01
        typ = st_r.xc1[pxm_pkg::XC1_TYPE_LO +: 2];
        case (typ) // RULE_06
            pxm_pkg::TYPE_RGMII: st_nxt.mode = pxm_pkg::MODE_RGMII;
            pxm_pkg::TYPE_RMII:  st_nxt.mode = pxm_pkg::MODE_RMII;
            pxm_pkg::TYPE_GMII:  st_nxt.mode = gig ? pxm_pkg::MODE_GMII : pxm_pkg::MODE_MII;
            default:             st_nxt.mode = pxm_pkg::MODE_MII;
        endcase
        if (gig) begin
            st_nxt.rate = pxm_pkg::RATE_1000; // RULE_01
        end else begin
            st_nxt.rate = i_speed_100 ? pxm_pkg::RATE_100 : pxm_pkg::RATE_10; // RULE_12
        end
        // Clock delay lines in whole system cycles
        st_nxt.rx_dly = st_r.xc1[pxm_pkg::XC1_RX_DLY] ? pxm_pkg::DLY_CYC : 4'h0; // RULE_02
        st_nxt.tx_dly = st_r.xc1[pxm_pkg::XC1_TX_DLY] ? pxm_pkg::DLY_CYC : 4'h0; // RULE_03
        // Role bit: clock direction per interface type
        st_nxt.mii_drive = (typ == pxm_pkg::TYPE_MII || (typ == pxm_pkg::TYPE_GMII && !gig))
                           && st_r.xc1[pxm_pkg::XC1_ROLE]; // RULE_04
        st_nxt.ref_oe = (typ == pxm_pkg::TYPE_RMII) && st_r.xc1[pxm_pkg::XC1_ROLE]; // RULE_05
        // Reference clock divider toggles every REF_HALF+1 cycles
        if (st_r.ref_oe) begin
            if (st_r.ref_cnt == pxm_pkg::REF_HALF) begin
                st_nxt.ref_cnt = 2'h0;
                st_nxt.ref_clk = ~st_r.ref_clk; // RULE_05
            end else begin
                st_nxt.ref_cnt = st_r.ref_cnt + 2'h1;
            end
        end else begin
            st_nxt.ref_cnt = 2'h0;
            st_nxt.ref_clk = 1'b0;
        end
        // Reference level seen by the port: own clock or the accepted input
        st_nxt.ref_lvl = st_r.ref_oe ? st_r.ref_clk : i_receive_clock_pin; // RULE_05
        // MAC controls
        st_nxt.storm   = st_r.mc0[pxm_pkg::MC0_STORM]; // RULE_07
        st_nxt.max_pay = st_r.mc0[pxm_pkg::MC0_JUMBO] ? pxm_pkg::PAYLOAD_JUMBO
                                                      : pxm_pkg::PAYLOAD_STD; // RULE_08
        st_nxt.backp   = st_r.mc1[pxm_pkg::MC1_BACKP] && !i_full_duplex; // RULE_09
        // Frame verdict, one-cycle pulses after the frame end
        st_nxt.drop   = 1'b0;
        st_nxt.mirror = 1'b0;
        if (i_frame_end) begin
            bad = i_crc_err || (i_payload_len > st_r.max_pay)
                  || (i_payload_len < pxm_pkg::PAYLOAD_MIN); // RULE_08
            if (i_flow_frame && i_flow_filter_en) begin
                st_nxt.drop = 1'b1; // RULE_11
            end else if (bad) begin
                st_nxt.drop   = ~st_r.mc1[pxm_pkg::MC1_PASS]; // RULE_10
                st_nxt.mirror = st_r.mc1[pxm_pkg::MC1_PASS];  // RULE_10
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r         <= '0;
            st_r.xc1     <= pxm_pkg::XC1_RESET;
            st_r.mc0     <= pxm_pkg::MC0_RESET;
            st_r.mc1     <= pxm_pkg::MC1_RESET;
            st_r.rate    <= pxm_pkg::RATE_1000;
            st_r.tx_dly  <= pxm_pkg::DLY_CYC;
            st_r.max_pay <= pxm_pkg::PAYLOAD_STD;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign o_rdata                = st_r.rdata;
    assign o_mode                 = st_r.mode;
    assign o_rate                 = st_r.rate;
    assign o_rx_delay_cyc         = st_r.rx_dly;
    assign o_tx_delay_cyc         = st_r.tx_dly;
    assign o_mii_clk_drive        = st_r.mii_drive;
    assign o_receive_clock_pin_o  = st_r.ref_clk;
    assign o_receive_clock_pin_oe = st_r.ref_oe;
    assign o_ref_clk_level        = st_r.ref_lvl;
    assign o_storm_protect        = st_r.storm;
    assign o_max_payload          = st_r.max_pay;
    assign o_backpressure         = st_r.backp;
    assign o_frame_drop           = st_r.drop;
    assign o_frame_mirror_only    = st_r.mirror;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_gig_rate: assert property (i_ce && !st_r.xc1[pxm_pkg::XC1_SPEED_LOW] // RULE_01
        |=> o_rate == pxm_pkg::RATE_1000)
        else $error("gigabit rate not selected");
    a_low_rate: assert property (i_ce && st_r.xc1[pxm_pkg::XC1_SPEED_LOW] // RULE_12
        |=> o_rate == ($past(i_speed_100) ? pxm_pkg::RATE_100 : pxm_pkg::RATE_10))
        else $error("10/100 rate wrong");
    a_rx_delay: assert property (i_ce ##1 i_ce // RULE_02
        |-> o_rx_delay_cyc == ($past(st_r.xc1[pxm_pkg::XC1_RX_DLY]) ? 4'h1 : 4'h0))
        else $error("rx delay mismatch");
    a_tx_delay: assert property ($fell(i_reset) |-> o_tx_delay_cyc == 4'h1) // RULE_03
        else $error("tx delay not on at reset");
    a_mii_role: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_MII // RULE_04
        |=> o_mii_clk_drive == $past(st_r.xc1[pxm_pkg::XC1_ROLE]))
        else $error("mii clock role wrong");
    a_ref_div: assert property (i_ce && o_receive_clock_pin_oe && $rose(o_receive_clock_pin_o) // RULE_05
        ##1 i_ce |=> $fell(o_receive_clock_pin_o))
        else $error("reference clock not 50 MHz");
    a_type_mode: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_RMII // RULE_06
        |=> o_mode == pxm_pkg::MODE_RMII)
        else $error("rmii mode not selected");
    a_storm_en: assert property (i_ce |=> o_storm_protect == $past(st_r.mc0[1])) // RULE_07
        else $error("storm enable not applied");
    a_jumbo_lim: assert property (i_ce |=> // RULE_08
        o_max_payload == ($past(st_r.mc0[0]) ? 14'h2328 : 14'h05dc))
        else $error("payload limit wrong");
    a_backp_half: assert property (i_ce |=> // RULE_09
        o_backpressure == ($past(st_r.mc1[pxm_pkg::MC1_BACKP]) && !$past(i_full_duplex)))
        else $error("back pressure in full duplex");
    a_bad_drop: assert property (i_ce && i_frame_end && i_crc_err && !i_flow_frame // RULE_10
        |=> o_frame_drop != o_frame_mirror_only && o_frame_mirror_only == $past(st_r.mc1[0]))
        else $error("bad frame verdict wrong");
    a_flow_filt: assert property (i_ce && i_frame_end && i_flow_frame && i_flow_filter_en // RULE_11
        |=> o_frame_drop && !o_frame_mirror_only)
        else $error("flow frame filtering changed");
    a_ro_bits: assert property (st_r.mc0[7:4] == 4'h0 && !st_r.mc0[2] && !st_r.mc1[6]) // RULE_13
        else $error("read-only bit changed");

    // Ingress delay starts off after reset
    a_rx_dly_rst: assert property ($fell(i_reset) |-> o_rx_delay_cyc == 4'h0) // RULE_02
        else $error("rx delay not off at reset");

    // Storm protection starts off after reset
    a_storm_rst: assert property ($fell(i_reset) |-> !o_storm_protect) // RULE_07
        else $error("storm protection on at reset");

    // Egress delay follows its control bit
    a_tx_dly_bit: assert property (i_ce |=> // RULE_03
        o_tx_delay_cyc == ($past(st_r.xc1[pxm_pkg::XC1_TX_DLY]) ? 4'h1 : 4'h0))
        else $error("tx delay mismatch");

    // Type 00 gives RGMII
    a_rgmii_mode: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_RGMII // RULE_06
        |=> o_mode == pxm_pkg::MODE_RGMII)
        else $error("rgmii mode not selected");

    // Type 10 gives GMII at gigabit, MII at 10/100
    a_gmii_mode: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_GMII // RULE_06
        |=> o_mode == ($past(st_r.xc1[pxm_pkg::XC1_SPEED_LOW]) ? pxm_pkg::MODE_MII : pxm_pkg::MODE_GMII))
        else $error("gmii or mii choice wrong");

    // Type 11 gives MII
    a_mii_mode: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_MII // RULE_06
        |=> o_mode == pxm_pkg::MODE_MII)
        else $error("mii mode not selected");

    // Type 10 at 10/100 is MII, so the role bit picks the clock side
    a_gmii_role: assert property (i_ce && st_r.xc1[1:0] == pxm_pkg::TYPE_GMII // RULE_04
        |=> o_mii_clk_drive == ($past(st_r.xc1[pxm_pkg::XC1_SPEED_LOW]) && $past(st_r.xc1[pxm_pkg::XC1_ROLE])))
        else $error("mii clock role wrong at type 10");

    // RGMII and RMII never drive the MII clocks
    a_rgmii_noclk: assert property (i_ce && !st_r.xc1[1] |=> !o_mii_clk_drive) // RULE_04
        else $error("clock drive outside mii");

    // Receive clock pin driven only in RMII with the role bit set
    a_rmii_oe: assert property (i_ce |=> // RULE_05
        o_receive_clock_pin_oe == ($past(st_r.xc1[1:0]) == pxm_pkg::TYPE_RMII
                                   && $past(st_r.xc1[pxm_pkg::XC1_ROLE])))
        else $error("receive clock pin direction wrong");

    // Own reference stays low while the pin is an input
    a_ref_quiet: assert property (i_ce && !o_receive_clock_pin_oe |=> !o_receive_clock_pin_o) // RULE_05
        else $error("reference clock runs while pin is an input");

    // Reference high phase lasts two cycles
    a_ref_hold: assert property (i_ce && o_receive_clock_pin_oe && $rose(o_receive_clock_pin_o) // RULE_05
        |=> $stable(o_receive_clock_pin_o))
        else $error("reference clock high for one cycle only");

    // Reference level in use: own clock when driving, else the pin
    a_ref_level: assert property (i_ce |=> // RULE_05
        o_ref_clk_level == $past(o_receive_clock_pin_oe ? o_receive_clock_pin_o : i_receive_clock_pin))
        else $error("reference level source wrong");

    // Good frames get no verdict pulse
    a_good_pass: assert property (i_ce && i_frame_end && !i_crc_err && !i_flow_frame // RULE_10
        && i_payload_len >= pxm_pkg::PAYLOAD_MIN && i_payload_len <= o_max_payload
        |=> !o_frame_drop && !o_frame_mirror_only)
        else $error("good frame given a verdict");

    // Oversize frames are bad against the current limit
    a_long_drop: assert property (i_ce && i_frame_end && !i_flow_frame && i_payload_len > o_max_payload // RULE_08
        |=> o_frame_drop == !$past(st_r.mc1[pxm_pkg::MC1_PASS]))
        else $error("oversize frame verdict wrong");

    // Undersize frames are bad as well
    a_short_drop: assert property (i_ce && i_frame_end && !i_flow_frame // RULE_10
        && i_payload_len < pxm_pkg::PAYLOAD_MIN
        |=> o_frame_mirror_only == $past(st_r.mc1[pxm_pkg::MC1_PASS]) && o_frame_drop != o_frame_mirror_only)
        else $error("undersize frame verdict wrong");

    // No verdict pulse without a frame end
    a_no_verdict: assert property (i_ce && !i_frame_end |=> !o_frame_drop && !o_frame_mirror_only) // RULE_10
        else $error("verdict pulse without a frame end");

    // Good flow frames pass when the switch-level filter is off
    a_flow_pass: assert property (i_ce && i_frame_end && i_flow_frame && !i_flow_filter_en // RULE_11
        && !i_crc_err && i_payload_len >= pxm_pkg::PAYLOAD_MIN && i_payload_len <= o_max_payload
        |=> !o_frame_drop && !o_frame_mirror_only)
        else $error("unfiltered flow frame dropped");

    // Full duplex never gets back pressure
    a_backp_full: assert property (i_ce && i_full_duplex |=> !o_backpressure) // RULE_09
        else $error("back pressure in full duplex mode");

    // Read-only bits of MAC control zero read back as zero
    a_ro_read: assert property (i_ce && i_rd && i_addr == pxm_pkg::ADDR_MAC_CTL0 // RULE_13
        |=> o_rdata[7:4] == 4'h0 && !o_rdata[2])
        else $error("reserved bits read back set");
endmodule

/* sim/pxm_phy_model.sv */
// Far-end MAC or PHY model that shares the receive clock pin with the switch
module pxm_phy_model (
    input  wire logic i_oe,
    output logic      o_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_r;
    // Free-running 50 MHz reference, as an outside RMII clock source gives
    initial begin
        ref_r = 1'b0;
        forever #10 ref_r = ~ref_r;
    end
    // Lets go of the pin while the switch generates the reference itself
    assign o_clk = i_oe ? 1'bz : ref_r;
endmodule

/* sim/pxm_ctrl_tb.sv */
// Self-checking bench for the xMII and MAC control register bank
module pxm_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset, i_ce, i_wr, i_rd, i_full_duplex, i_speed_100, i_frame_end, i_crc_err;
    logic i_flow_frame, i_flow_filter_en, o_mii_clk_drive, o_receive_clock_pin_o, o_receive_clock_pin_oe;
    logic o_ref_clk_level, o_storm_protect, o_backpressure, o_frame_drop, o_frame_mirror_only;
    logic [15:0] i_addr;
    logic [7:0]  i_wdata, o_rdata, d, e;
    logic [13:0] i_payload_len, o_max_payload, mx;
    logic [1:0]  o_mode, o_rate, md;
    logic [3:0]  o_rx_delay_cyc, o_tx_delay_cyc;
    logic        v, w, bad, flt;
    wire         i_receive_clock_pin, phy_clk;
    int          n_mismatch, samples_checked;
    localparam logic [13:0] LENS[6] = '{14'h002d, 14'h002e, 14'h05dc, 14'h05dd, 14'h2328, 14'h2329};

    pxm_ctrl u_pxm_ctrl (.i_clk, .i_reset, .i_ce, .i_wr, .i_rd, .i_addr, .i_wdata, .i_full_duplex,
        .i_speed_100, .i_frame_end, .i_crc_err, .i_payload_len, .i_flow_frame, .i_flow_filter_en,
        .i_receive_clock_pin, .o_rdata, .o_mode, .o_rate, .o_rx_delay_cyc, .o_tx_delay_cyc,
        .o_mii_clk_drive, .o_receive_clock_pin_o, .o_receive_clock_pin_oe, .o_ref_clk_level,
        .o_storm_protect, .o_max_payload, .o_backpressure, .o_frame_drop, .o_frame_mirror_only);
    pxm_phy_model u_pxm_phy_model (.i_oe(o_receive_clock_pin_oe), .o_clk(phy_clk));
    // Shared pin level: the switch wins while it drives, else the far end
    assign i_receive_clock_pin = o_receive_clock_pin_oe ? o_receive_clock_pin_o : phy_clk;

    // Compares one result against the model
    task automatic chk(string nm, logic [13:0] ex, logic [13:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    // Moves to just after the next rising edge
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    // One register access, write when w is high, else read
    task automatic acc(logic w, logic [15:0] a, logic [7:0] dat);
        tick();
        i_wr = w;
        i_rd = !w;
        i_addr = a;
        i_wdata = dat;
        tick();
        i_wr = 1'b0;
        i_rd = 1'b0;
    endtask
    // Prints the counts and the verdict, then stops
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // System clock, 200 MHz
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial begin
        {i_wr, i_rd, i_frame_end, i_crc_err, i_flow_frame, i_flow_filter_en, i_speed_100} = '0;
        {i_ce, i_full_duplex, i_reset} = 3'h7;
        {i_addr, i_wdata, i_payload_len} = '0;
        void'($urandom(20363));
        repeat (8) @(posedge i_clk);
        #1 i_reset = 1'b0;
        chk("mode", 14'h0000, o_mode);
        chk("rate", 14'h0002, o_rate);
        chk("rxdly", 14'h0000, o_rx_delay_cyc);
        chk("txdly", 14'h0001, o_tx_delay_cyc);
        chk("storm", 14'h0000, o_storm_protect);
        acc(0, pxm_pkg::ADDR_XMII_CTL1, 8'h00);
        chk("rd_x1", 14'h0008, o_rdata);
        acc(0, pxm_pkg::ADDR_MAC_CTL0, 8'h00);
        chk("rd_m0", 14'h0000, o_rdata);
        acc(0, pxm_pkg::ADDR_MAC_CTL1, 8'h00);
        chk("rd_m1", 14'h0000, o_rdata);
        acc(0, 16'h6402, 8'h00);
        chk("rd_unmapped", 14'h0000, o_rdata);
        // Every type code against both speed settings and both roles
        for (int i = 0; i < 32; i++) begin
            d = 8'($urandom());
            {d[2], d[6], d[1:0]} = i[3:0];
            i_speed_100 = 1'($urandom());
            acc(1, pxm_pkg::ADDR_XMII_CTL1, d);
            tick();
            md = (d[1:0] == 2'h2) ? (d[6] ? 2'h3 : 2'h2) : d[1:0];
            chk("mode", md, o_mode);
            chk("rate", d[6] ? {1'b0, i_speed_100} : 2'h2, o_rate);
            chk("rxdly", d[4], o_rx_delay_cyc);
            chk("txdly", d[3], o_tx_delay_cyc);
            chk("clkdrv", d[2] && md == 2'h3, o_mii_clk_drive);
            chk("pin_oe", d[2] && md == 2'h1, o_receive_clock_pin_oe);
            v = o_receive_clock_pin_o;
            tick();
            w = o_receive_clock_pin_o;
            tick();
            if (d[2] && md == 2'h1)
                chk("refclk", 14'h0001, v ^ o_receive_clock_pin_o);
            // Level in use lags one cycle: own clock when driving, else the far end
            chk("reflvl", (d[2] && md == 2'h1) ? w : phy_clk, o_ref_clk_level);
            acc(0, pxm_pkg::ADDR_XMII_CTL1, 8'h00);
            chk("rd_x1", d, o_rdata);
        end
        // MAC controls, then a burst of back-to-back frame verdicts
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom());
            e = 8'($urandom());
            i_full_duplex = 1'($urandom());
            i_flow_filter_en = 1'($urandom());
            acc(1, pxm_pkg::ADDR_MAC_CTL0, d);
            acc(1, pxm_pkg::ADDR_MAC_CTL1, e);
            tick();
            mx = d[0] ? 14'h2328 : 14'h05dc;
            chk("storm", d[1], o_storm_protect);
            chk("maxpay", mx, o_max_payload);
            chk("backp", e[3] && !i_full_duplex, o_backpressure);
            for (int j = 0; j < 8; j++) begin
                i_frame_end = 1'b1;
                i_crc_err = ($urandom() % 4) == 0;
                i_flow_frame = ($urandom() % 4) == 0;
                i_payload_len = j[0] ? LENS[$urandom() % 6] : 14'($urandom_range(9100));
                bad = i_crc_err || i_payload_len > mx || i_payload_len < 14'h002e;
                flt = i_flow_frame && i_flow_filter_en;
                tick();
                chk("drop", flt || (bad && !e[0]), o_frame_drop);
                chk("mirror", bad && e[0] && !flt, o_frame_mirror_only);
            end
            i_frame_end = 1'b0;
            tick();
            chk("drop_idle", 14'h0000, o_frame_drop | o_frame_mirror_only);
            acc(0, pxm_pkg::ADDR_MAC_CTL0, 8'h00);
            chk("rd_m0", d & 8'h0b, o_rdata);
            acc(0, pxm_pkg::ADDR_MAC_CTL1, 8'h00);
            chk("rd_m1", e & 8'hbf, o_rdata);
        end
        // Clock enable low freezes the bank: a write is lost, outputs hold
        i_ce = 1'b0;
        acc(1, pxm_pkg::ADDR_MAC_CTL0, ~d);
        tick();
        chk("ce_maxpay", mx, o_max_payload);
        chk("ce_storm", d[1], o_storm_protect);
        i_ce = 1'b1;
        acc(0, pxm_pkg::ADDR_MAC_CTL0, 8'h00);
        chk("ce_rd_m0", d & 8'h0b, o_rdata);
        // Reset in mid run brings back the defaults
        i_reset = 1'b1;
        tick();
        i_reset = 1'b0;
        chk("txdly_rst", 14'h0001, o_tx_delay_cyc);
        chk("rxdly_rst", 14'h0000, o_rx_delay_cyc);
        chk("maxpay_rst", 14'h05dc, o_max_payload);
        acc(0, pxm_pkg::ADDR_MAC_CTL1, 8'h00);
        chk("rd_m1_rst", 14'h0000, o_rdata);
        final_report();
    end
endmodule
